// ==== rtl/afh_pkg.sv ====
// How it works
// - clear pulse issued before any push
// - both strobes high around clear rise
// - both strobes high during replay pulse
// - pusher watches full, popper watches empty
package afh_pkg;

  // ------------------------------------------------------------
  // widths and clock
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WORD_W = 9;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned TIMER_W = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // pin timing, slowest grade
  // ------------------------------------------------------------
  localparam int unsigned STROBE_LOW_NS = 120;
  localparam int unsigned READ_ACCESS_NS = 120;
  localparam int unsigned CLEAR_SETUP_NS = 120;
  localparam int unsigned CLEAR_LOW_NS = 120;
  localparam int unsigned REPLAY_SETUP_NS = 120;
  localparam int unsigned REPLAY_LOW_NS = 120;
  localparam int unsigned FLAG_SETTLE_NS = 140;

  // least time in ns to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned r;
    r = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (r < 1) begin
      r = 1;
    end
    return r;
  endfunction : ns_to_cyc

  localparam int unsigned STROBE_LOW_CYC = ns_to_cyc(STROBE_LOW_NS);
  // read low also covers access time plus the synchroniser lag
  localparam int unsigned READ_LOW_CYC = ((STROBE_LOW_NS > READ_ACCESS_NS) ? STROBE_LOW_CYC :
                                          ns_to_cyc(READ_ACCESS_NS)) + SYNC_STAGES;
  localparam int unsigned CLEAR_SETUP_CYC = ns_to_cyc(CLEAR_SETUP_NS);
  localparam int unsigned CLEAR_LOW_CYC = ns_to_cyc(CLEAR_LOW_NS);
  localparam int unsigned REPLAY_SETUP_CYC = ns_to_cyc(REPLAY_SETUP_NS);
  localparam int unsigned REPLAY_LOW_CYC = ns_to_cyc(REPLAY_LOW_NS);
  // recovery covers write/read/clear recovery and flag settling
  localparam int unsigned RECOVER_CYC = ns_to_cyc(FLAG_SETTLE_NS) + SYNC_STAGES;

  // timer load value for a stay of cyc cycles
  function automatic logic [TIMER_W-1:0] cyc_load(input int unsigned cyc);
    return TIMER_W'(cyc - 1);
  endfunction : cyc_load

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PUSH = 8'h04;
  localparam logic [ADDR_W-1:0] REG_POP_WORD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PUSH_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_POP_COUNT = 8'h14;

  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned CTRL_REPLAY_BIT = 1;
  localparam int unsigned CTRL_POP_BIT = 2;

  localparam int unsigned ST_FULL_BIT = 0;
  localparam int unsigned ST_EMPTY_BIT = 1;
  localparam int unsigned ST_HALF_BIT = 2;
  localparam int unsigned ST_BUSY_BIT = 3;
  localparam int unsigned ST_PUSH_REFUSED_BIT = 4;
  localparam int unsigned ST_POP_REFUSED_BIT = 5;
  localparam int unsigned ST_WORD_NEW_BIT = 6;
  localparam int unsigned ST_CMD_REFUSED_BIT = 7;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    AFH_IDLE,
    AFH_PUSH_LOW,
    AFH_POP_LOW,
    AFH_CLEAR_SETUP,
    AFH_CLEAR_LOW,
    AFH_REPLAY_SETUP,
    AFH_REPLAY_LOW,
    AFH_RECOVER
  } afh_state_type;

endpackage : afh_pkg

// ==== rtl/afh_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for pins from the device
module afh_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import afh_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } afh_sync_type;

  afh_sync_type q, d;

  // first stage feeds only the second stage
  always_comb begin
    d.meta = async_in;
    d.sync = q.meta;
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.sync;
endmodule : afh_sync

// ==== rtl/afh_timer.sv ====
`timescale 1ns/1ps
// down counter timing each pin phase; done when it reaches zero
module afh_timer #(
  parameter logic [afh_pkg::TIMER_W-1:0] RESET_COUNT = '0
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [afh_pkg::TIMER_W-1:0] value_in,
  output logic done_out
);
  import afh_pkg::*;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
  } afh_timer_type;

  afh_timer_type q, d;

  // load wins over counting; holds at zero
  always_comb begin
    d = q;
    if (load_in) begin
      d.count = value_in;
    end else if (q.count != '0) begin
      d.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      q.count <= RESET_COUNT;
    end else begin
      q <= d;
    end
  end

  assign done_out = (q.count == '0);
endmodule : afh_timer

// ==== rtl/afh_host.sv ====
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// host-side sequencer driving the pins of an asynchronous nine-bit buffer
module afh_host (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [afh_pkg::ADDR_W-1:0] addr_in,
  input wire logic [afh_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [afh_pkg::DATA_W-1:0] rdata_out,
  output logic busy_out,
  output logic push_pulse_n_out,
  output logic pop_pulse_n_out,
  output logic clear_pointers_n_out,
  output logic first_load_or_replay_n_out,
  output logic chain_in_n_out,
  output logic [afh_pkg::WORD_W-1:0] write_word_out,
  input wire logic [afh_pkg::WORD_W-1:0] read_word_in,
  input wire logic full_indicator_n_in,
  input wire logic empty_indicator_n_in,
  input wire logic chain_out_or_half_level_in
);
  import afh_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    afh_state_type state;
    logic push_n;
    logic pop_n;
    logic clear_n;
    logic replay_n;
    logic [WORD_W-1:0] wword;
    logic [WORD_W-1:0] rword;
    logic [DATA_W-1:0] rdata;
    logic push_refused;
    logic pop_refused;
    logic word_new;
    logic cmd_refused;
    logic [COUNT_W-1:0] push_count;
    logic [COUNT_W-1:0] pop_count;
  } afh_host_type;

  // q holds the registered state, d its next value
  afh_host_type q, d;
  // timer and synchroniser hookups
  logic timer_load;
  logic [TIMER_W-1:0] timer_value;
  logic timer_done;
  logic [WORD_W+2:0] pins_sync;
  logic [WORD_W-1:0] rword_sync;
  logic full_sync_n;
  logic empty_sync_n;
  logic half_sync_n;
  logic [DATA_W-1:0] status_word;
  logic push_cmd;
  logic ctrl_cmd;
  logic status_wr;

  // ------------------------------------------------------------
  // pin synchronisers and phase timer
  // ------------------------------------------------------------
  // data bus is sampled only late in the pop pulse, so its lag is harmless
  afh_sync #(
    .WIDTH(WORD_W + 3)
  ) u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in({chain_out_or_half_level_in, empty_indicator_n_in, full_indicator_n_in, read_word_in}),
    .sync_out(pins_sync)
  );

  // the clear pulse after reset is timed from the reset value
  afh_timer #(
    .RESET_COUNT(cyc_load(CLEAR_LOW_CYC))
  ) u_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .load_in(timer_load),
    .value_in(timer_value),
    .done_out(timer_done)
  );

  // split the synchronised pins back out
  assign rword_sync = pins_sync[WORD_W-1:0];
  assign full_sync_n = pins_sync[WORD_W];
  assign empty_sync_n = pins_sync[WORD_W+1];
  // half level read
  // single-device mode: the shared output carries the half level
  assign half_sync_n = pins_sync[WORD_W+2];

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  // a control write with no action bit set is simply ignored
  assign push_cmd = wr_in && (addr_in == REG_PUSH);
  assign ctrl_cmd = wr_in && (addr_in == REG_CTRL) && (wdata_in[CTRL_POP_BIT:CTRL_CLEAR_BIT] != '0);
  assign status_wr = wr_in && (addr_in == REG_STATUS);

  // flags reported active high
  always_comb begin
    status_word = '0;
    status_word[ST_FULL_BIT] = ~full_sync_n;
    status_word[ST_EMPTY_BIT] = ~empty_sync_n;
    status_word[ST_HALF_BIT] = ~half_sync_n;
    status_word[ST_BUSY_BIT] = (q.state != AFH_IDLE);
    status_word[ST_PUSH_REFUSED_BIT] = q.push_refused;
    status_word[ST_POP_REFUSED_BIT] = q.pop_refused;
    status_word[ST_WORD_NEW_BIT] = q.word_new;
    status_word[ST_CMD_REFUSED_BIT] = q.cmd_refused;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    timer_load = 1'b0;
    timer_value = '0;
    d.rdata = '0;

    // read data for the cycle after the strobe; unmapped reads give zero
    if (rd_in) begin
      case (addr_in)
        REG_POP_WORD: d.rdata = {{(DATA_W - WORD_W){1'b0}}, q.rword};
        REG_STATUS: d.rdata = status_word;
        REG_PUSH_COUNT: d.rdata = {{(DATA_W - COUNT_W){1'b0}}, q.push_count};
        REG_POP_COUNT: d.rdata = {{(DATA_W - COUNT_W){1'b0}}, q.pop_count};
        default: d.rdata = '0;
      endcase
    end

    // clears come first so a set later in this cycle wins
    if (rd_in && (addr_in == REG_POP_WORD)) begin
      d.word_new = 1'b0;
    end
    if (status_wr) begin
      if (wdata_in[ST_PUSH_REFUSED_BIT]) d.push_refused = 1'b0;
      if (wdata_in[ST_POP_REFUSED_BIT]) d.pop_refused = 1'b0;
      if (wdata_in[ST_WORD_NEW_BIT]) d.word_new = 1'b0;
      if (wdata_in[ST_CMD_REFUSED_BIT]) d.cmd_refused = 1'b0;
    end

    // no queueing: a command during a sequence is dropped and flagged
    if ((push_cmd || ctrl_cmd) && (q.state != AFH_IDLE)) begin
      d.cmd_refused = 1'b1;
    end

    // pin flags are looked at only here, at command time
    case (q.state)
      AFH_IDLE: begin
        if (push_cmd) begin
          if (full_sync_n) begin
            d.wword = wdata_in[WORD_W-1:0];
            d.push_n = 1'b0;
            timer_load = 1'b1;
            timer_value = cyc_load(STROBE_LOW_CYC);
            d.state = AFH_PUSH_LOW;
          end else begin
            d.push_refused = 1'b1;
          end
        end else if (ctrl_cmd) begin
          // clear wins over replay, replay over pop
          if (wdata_in[CTRL_CLEAR_BIT]) begin
            timer_load = 1'b1;
            timer_value = cyc_load(CLEAR_SETUP_CYC);
            d.state = AFH_CLEAR_SETUP;
          end else if (wdata_in[CTRL_REPLAY_BIT]) begin
            timer_load = 1'b1;
            timer_value = cyc_load(REPLAY_SETUP_CYC);
            d.state = AFH_REPLAY_SETUP;
          end else if (empty_sync_n) begin
            d.pop_n = 1'b0;
            timer_load = 1'b1;
            timer_value = cyc_load(READ_LOW_CYC);
            d.state = AFH_POP_LOW;
          end else begin
            d.pop_refused = 1'b1;
          end
        end
      end
      AFH_PUSH_LOW: begin
        // word stands on the bus through the rising edge
        if (timer_done) begin
          d.push_n = 1'b1;
          d.push_count = q.push_count + 1'b1;
          timer_load = 1'b1;
          timer_value = cyc_load(RECOVER_CYC);
          d.state = AFH_RECOVER;
        end
      end
      AFH_POP_LOW: begin
        // sample while driven
        // capture before the rise; the bus floats once pop goes high
        if (timer_done) begin
          d.pop_n = 1'b1;
          d.rword = rword_sync;
          d.word_new = 1'b1;
          d.pop_count = q.pop_count + 1'b1;
          timer_load = 1'b1;
          timer_value = cyc_load(RECOVER_CYC);
          d.state = AFH_RECOVER;
        end
      end
      AFH_CLEAR_SETUP: begin
        if (timer_done) begin
          d.clear_n = 1'b0;
          timer_load = 1'b1;
          timer_value = cyc_load(CLEAR_LOW_CYC);
          d.state = AFH_CLEAR_LOW;
        end
      end
      AFH_CLEAR_LOW: begin
        if (timer_done) begin
          d.clear_n = 1'b1;
          // counters restart with the device pointers
          d.push_count = '0;
          d.pop_count = '0;
          timer_load = 1'b1;
          timer_value = cyc_load(RECOVER_CYC);
          d.state = AFH_RECOVER;
        end
      end
      AFH_REPLAY_SETUP: begin
        if (timer_done) begin
          d.replay_n = 1'b0;
          timer_load = 1'b1;
          timer_value = cyc_load(REPLAY_LOW_CYC);
          d.state = AFH_REPLAY_LOW;
        end
      end
      AFH_REPLAY_LOW: begin
        if (timer_done) begin
          d.replay_n = 1'b1;
          // read pointer restarts, so pops are counted again from zero
          d.pop_count = '0;
          timer_load = 1'b1;
          timer_value = cyc_load(RECOVER_CYC);
          d.state = AFH_RECOVER;
        end
      end
      AFH_RECOVER: begin
        // flags settle and pass the synchroniser before the next check
        if (timer_done) begin
          d.state = AFH_IDLE;
        end
      end
      default: begin
        // an unused encoding falls back to idle
        d.state = AFH_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // clear before pushes
  // reset starts straight in the clear pulse; strobes are already high
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
      q.state <= AFH_CLEAR_LOW;
      q.push_n <= 1'b1;
      q.pop_n <= 1'b1;
      q.clear_n <= 1'b0;
      q.replay_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every pin but chain_in_n_out (tied low) comes from a flop, so no glitch reaches the device
  assign rdata_out = q.rdata;
  assign busy_out = (q.state != AFH_IDLE);
  assign push_pulse_n_out = q.push_n;
  assign pop_pulse_n_out = q.pop_n;
  assign clear_pointers_n_out = q.clear_n;
  // first-load pin idle high
  // high when idle: no replay, and never first device of a chain
  assign first_load_or_replay_n_out = q.replay_n;
  assign chain_in_n_out = 1'b0;
  // the word stays on the pins until the next push
  assign write_word_out = q.wword;
endmodule : afh_host

// ==== verification/afh_host_props.sv ====
`timescale 1ns/1ps
// pin-level checks on the host sequencer
module afh_host_props (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic push_pulse_n_out,
  input wire logic pop_pulse_n_out,
  input wire logic clear_pointers_n_out,
  input wire logic first_load_or_replay_n_out,
  input wire logic chain_in_n_out,
  input wire logic full_indicator_n_in,
  input wire logic empty_indicator_n_in
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // strobe widths: push twelve cycles low, pop fourteen
  sequence push_low12;
    (!push_pulse_n_out) [*8] ##1 (!push_pulse_n_out) [*4] ##1 push_pulse_n_out;
  endsequence
  sequence pop_low14;
    (!pop_pulse_n_out) [*8] ##1 (!pop_pulse_n_out) [*6] ##1 pop_pulse_n_out;
  endsequence

  a_push_width: assert property ($fell(push_pulse_n_out) |-> push_low12)
    else $error("push strobe width wrong");
  a_pop_width: assert property ($fell(pop_pulse_n_out) |-> pop_low14)
    else $error("pop strobe width wrong");
  // flags pass two flops, so the decision saw them a few edges back
  a_push_room: assert property ($fell(push_pulse_n_out) |->
    $past(full_indicator_n_in, 2) || $past(full_indicator_n_in, 3) || $past(full_indicator_n_in, 4))
    else $error("push issued while full");
  a_pop_data: assert property ($fell(pop_pulse_n_out) |->
    $past(empty_indicator_n_in, 2) || $past(empty_indicator_n_in, 3) || $past(empty_indicator_n_in, 4))
    else $error("pop issued while empty");
  a_clear_quiet: assert property (!clear_pointers_n_out |->
    push_pulse_n_out && pop_pulse_n_out && first_load_or_replay_n_out)
    else $error("strobe low during clear");
  a_clear_recover: assert property ($rose(clear_pointers_n_out) |->
    (push_pulse_n_out && pop_pulse_n_out) [*8])
    else $error("strobe low in clear recovery");
  a_replay_quiet: assert property (!first_load_or_replay_n_out |->
    push_pulse_n_out && pop_pulse_n_out)
    else $error("strobe low during replay");
  a_first_clear: assert property ($fell(reset_in) |->
    (!clear_pointers_n_out && push_pulse_n_out) [*8])
    else $error("no clear before first push");
  a_single_mode: assert property (chain_in_n_out == 1'b0)
    else $error("chain input not grounded");
endmodule : afh_host_props

bind afh_host afh_host_props afh_host_props_i (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .push_pulse_n_out(push_pulse_n_out),
  .pop_pulse_n_out(pop_pulse_n_out),
  .clear_pointers_n_out(clear_pointers_n_out),
  .first_load_or_replay_n_out(first_load_or_replay_n_out),
  .chain_in_n_out(chain_in_n_out),
  .full_indicator_n_in(full_indicator_n_in),
  .empty_indicator_n_in(empty_indicator_n_in)
);

// ==== verification/afh_fifo_model.sv ====
`timescale 1ns/1ps
// behavioural nine-bit buffer; flags follow occupancy at once
module afh_fifo_model #(
  parameter int DEPTH = 2048
) (
  input wire logic push_n_in,
  input wire logic pop_n_in,
  input wire logic clear_n_in,
  input wire logic replay_n_in,
  input wire logic chain_in_n_in,
  input wire logic [8:0] word_in,
  output logic [8:0] word_out,
  output logic full_n_out,
  output logic empty_n_out,
  output logic half_n_out
);
  // nine-bit store, indexed by pointer modulo depth
  logic [8:0] mem [DEPTH];
  logic [8:0] last_q = '0;
  int wp = 0;
  int rp = 0;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  always @(negedge clear_n_in) begin
    wp = 0;
    rp = 0;
  end
  // replay rewinds the read side only
  always @(negedge replay_n_in) rp = 0;
  // write accepted only with room, stored at rising edge
  always @(negedge push_n_in) wr_ok = clear_n_in && (wp - rp < DEPTH);
  always @(posedge push_n_in) begin
    if (wr_ok) begin
      mem[wp % DEPTH] = word_in;
      wp++;
    end
    wr_ok = 1'b0;
  end
  always @(negedge pop_n_in) begin
    rd_ok = clear_n_in && (wp != rp);
    if (rd_ok) last_q = mem[rp % DEPTH];
  end
  always @(posedge pop_n_in) begin
    if (rd_ok) rp++;
    rd_ok = 1'b0;
  end
  // released bus shows the inverse, so stale data never passes
  assign word_out = (!pop_n_in && rd_ok) ? last_q : ~last_q;
  assign full_n_out = (wp - rp) < DEPTH;
  assign empty_n_out = wp != rp;
  // grounded chain input shows half level, never chain pulses
  assign half_n_out = chain_in_n_in || !((wp - rp) > DEPTH / 2);
endmodule : afh_fifo_model

// ==== verification/tb_afh_host.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_afh_host;
  import afh_pkg::*;
  localparam int DEPTH = 16;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic busy_out, push_n, pop_n, clear_n, replay_n, chain_n, full_n, empty_n, half_n;
  logic [WORD_W-1:0] wword, rword;
  logic [WORD_W-1:0] q[$];
  logic [WORD_W-1:0] saved[$];
  logic [DATA_W-1:0] d;
  logic [WORD_W-1:0] exp_w;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int occ = 0;

  afh_host afh_host_i (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out), .push_pulse_n_out(push_n),
    .pop_pulse_n_out(pop_n), .clear_pointers_n_out(clear_n), .first_load_or_replay_n_out(replay_n),
    .chain_in_n_out(chain_n), .write_word_out(wword), .read_word_in(rword), .full_indicator_n_in(full_n),
    .empty_indicator_n_in(empty_n), .chain_out_or_half_level_in(half_n));
  afh_fifo_model #(.DEPTH(DEPTH)) afh_fifo_model_i (.push_n_in(push_n), .pop_n_in(pop_n),
    .clear_n_in(clear_n), .replay_n_in(replay_n), .chain_in_n_in(chain_n), .word_in(wword),
    .word_out(rword), .full_n_out(full_n), .empty_n_out(empty_n), .half_n_out(half_n));

  task automatic complete_run();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  // bounded wait for the sequencer to go idle
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      #1 n++;
    end while (busy_out !== 1'b0 && n < 300);
    if (n >= 300) failures++;
  endtask : idle
  // expected {half, empty, full} for an occupancy
  function automatic logic [2:0] flags(input int n);
    return {n > DEPTH / 2, n == 0, n == DEPTH};
  endfunction : flags
  task automatic chk_flags();
    rd(REG_STATUS);
    `CHK(d[2:0], flags(occ))
  endtask : chk_flags
  task automatic push(input logic [WORD_W-1:0] w);
    wr(REG_PUSH, DATA_W'(w));
    idle();
    if (occ < DEPTH) begin
      q.push_back(w);
      occ++;
    end
    chk_flags();
  endtask : push
  task automatic pop();
    wr(REG_CTRL, 32'h4);
    idle();
    rd(REG_POP_WORD);
    if (occ > 0) begin
      exp_w = q.pop_front();
      `CHK(d[WORD_W-1:0], exp_w)
      occ--;
    end
    chk_flags();
  endtask : pop
  task automatic end_test(input string n);
    $display("test %s done: %0d compares, %0d failures", n, cmp_count, failures);
  endtask : end_test

  // clock and hang guard
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(99));
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    idle();
    rd(REG_STATUS);
    `CHK(d[3:0], 4'h2)
    end_test("reset");
    // replay gives the same words again from the start
    for (int i = 0; i < 5; i++) push(WORD_W'($urandom));
    saved = q;
    pop();
    pop();
    wr(REG_CTRL, 32'h2);
    idle();
    q = saved;
    occ = 5;
    rd(REG_POP_COUNT);
    `CHK(d[15:0], 16'h0000)
    chk_flags();
    repeat (5) pop();
    end_test("replay");
    // clear empties; a pop on empty is refused
    wr(REG_CTRL, 32'h1);
    idle();
    q.delete();
    occ = 0;
    rd(REG_PUSH_COUNT);
    `CHK(d[15:0], 16'h0000)
    pop();
    rd(REG_STATUS);
    `CHK(d[ST_POP_REFUSED_BIT], 1'b1)
    wr(REG_STATUS, 32'hf0);
    end_test("empty");
    // fill to depth with edge words first, then one push too many
    push(9'h000);
    push(9'h1ff);
    while (occ < DEPTH) push(WORD_W'($urandom));
    push(9'h155);
    rd(REG_STATUS);
    `CHK(d[ST_PUSH_REFUSED_BIT], 1'b1)
    rd(REG_PUSH_COUNT);
    `CHK(d[15:0], 16'(DEPTH))
    wr(REG_STATUS, 32'hf0);
    while (occ > 0) pop();
    end_test("full");
    // a command while busy is dropped; the popped word is flagged new
    wr(REG_PUSH, 32'h0aa);
    wr(REG_CTRL, 32'h4);
    idle();
    rd(REG_STATUS);
    `CHK(d[ST_CMD_REFUSED_BIT], 1'b1)
    wr(REG_CTRL, 32'h4);
    idle();
    rd(REG_STATUS);
    `CHK(d[ST_WORD_NEW_BIT], 1'b1)
    rd(REG_POP_WORD);
    `CHK(d[WORD_W-1:0], 9'h0aa)
    wr(REG_STATUS, 32'hf0);
    rd(REG_STATUS);
    `CHK(d[7:0], 8'h02)
    end_test("refuse");
    rd(8'h20);
    `CHK(d, 32'h0000_0000)
    end_test("unmapped");
    complete_run();
  end
endmodule : tb_afh_host
